/* design/ir_remote_defs.vh */
`ifndef IR_REMOTE_DEFS_VH
`define IR_REMOTE_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets (data memory addresses)
// ----------------------------------------------------------------------------
`define ADDR_TIMER_COUNT_LOW   8'h18
`define ADDR_TIMER_CONTROL     8'h19
`define ADDR_LOW_PERIOD_LO     8'h1a
`define ADDR_LOW_PERIOD_HI     8'h1b
`define ADDR_HIGH_PERIOD_LO    8'h1c
`define ADDR_HIGH_PERIOD_HI    8'h1d

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_COUNT8_BIT        0
`define CTRL_ENABLE_BIT        1
`define CTRL_END_BIT           7
`define PERIOD_BIT8            0
`define PERIOD_INHIBIT_BIT     1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RST_BYTE               8'h00
`define RST_COUNT              9'h000
`define RST_INHIBIT            1'b1
`define RST_END_FLAG           1'b1
`define TICK_DIVIDE            6'h3f
`define TICK_ZERO              6'h00
`define TICK_STEP              6'h01
`define COUNT_ZERO             9'h000
`define COUNT_ONE              9'h001

`endif

/* design/ir_remote_timer_carrier.v */
`include "ir_remote_defs.vh"

module ir_remote_timer_carrier (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Data memory bus
    input  wire [7:0] memAddr,
    input  wire       memWrite,
    input  wire       memRead,
    input  wire [7:0] memWriteData,
    output reg  [7:0] memReadData,
    // Remote output
    output reg        remoteOutPin
);

    reg  [7:0] timerCountLow_reg;
    reg        countBitEight_reg;
    reg        timerOutputEnable_reg;
    reg        timerEndFlag_reg;
    reg  [8:0] downCount_reg;
    reg        running_reg;
    reg  [5:0] tickDiv_reg;
    reg  [8:0] lowPeriod_reg;
    reg  [8:0] highPeriod_reg;
    reg        carrierInhibit_reg;
    reg  [8:0] carrierCount_reg;
    reg        carrierHigh_reg;
    reg        window_reg;
    reg  [7:0] readData_next;
    reg        remote_next;
    reg  [8:0] carrierCount_next;
    reg        carrierHigh_next;

    // Carrier phase encoding
    localparam CARRIER_LOW  = 1'b0;
    localparam CARRIER_HIGH = 1'b1;

    // ------------------------------------------------------------------------
    // Address decode and control decisions
    // ------------------------------------------------------------------------
    // One address comparator shared by every register strobe
    function hitAddr;
        input [7:0] addr;
        input [7:0] target;
        begin
            hitAddr = (addr == target);
        end
    endfunction

    wire wrLow     = memWrite && hitAddr(memAddr, `ADDR_TIMER_COUNT_LOW);
    wire wrCtrl    = memWrite && hitAddr(memAddr, `ADDR_TIMER_CONTROL);
    wire wrLowLo   = memWrite && hitAddr(memAddr, `ADDR_LOW_PERIOD_LO);
    wire wrLowHi   = memWrite && hitAddr(memAddr, `ADDR_LOW_PERIOD_HI);
    wire wrHighLo  = memWrite && hitAddr(memAddr, `ADDR_HIGH_PERIOD_LO);
    wire wrHighHi  = memWrite && hitAddr(memAddr, `ADDR_HIGH_PERIOD_HI);
    wire enSet     = wrCtrl && memWriteData[`CTRL_ENABLE_BIT];
    wire enRise    = enSet && !timerOutputEnable_reg;
    // A control write reloads unless it confirms or stops a running count
    wire ctrlLoad  = wrCtrl && (enRise || !timerOutputEnable_reg || !running_reg);
    wire ctrlStop  = wrCtrl && !ctrlLoad && !enSet;
    wire countZero = (downCount_reg == `COUNT_ZERO);
    wire tick      = running_reg && (tickDiv_reg == `TICK_DIVIDE);

    // Reading a register image with reserved bits forced to zero
    function [7:0] hiByte;
        input bit8;
        input bit9;
        begin
            hiByte = {6'h00, bit9, bit8};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            timerCountLow_reg     <= `RST_BYTE;
            countBitEight_reg     <= 1'b0;
            timerOutputEnable_reg <= 1'b0;
        end
        else
        begin
            if (wrLow)
                timerCountLow_reg <= memWriteData;
            if (wrCtrl)
            begin
                countBitEight_reg     <= memWriteData[`CTRL_COUNT8_BIT];
                timerOutputEnable_reg <= memWriteData[`CTRL_ENABLE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Carrier period registers
    // ------------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            lowPeriod_reg      <= `RST_COUNT;
            highPeriod_reg     <= `RST_COUNT;
            carrierInhibit_reg <= `RST_INHIBIT;
        end
        else
        begin
            // Changing periods mid-burst is not guarded; software keeps the pin low
            if (wrLowLo)
                lowPeriod_reg[7:0] <= memWriteData;
            if (wrLowHi)
                lowPeriod_reg[8] <= memWriteData[`PERIOD_BIT8];
            if (wrHighLo)
                highPeriod_reg[7:0] <= memWriteData;
            if (wrHighHi)
            begin
                highPeriod_reg[8]  <= memWriteData[`PERIOD_BIT8];
                carrierInhibit_reg <= memWriteData[`PERIOD_INHIBIT_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Timer: down counter, prescaler, zero detector
    // ------------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            downCount_reg    <= `RST_COUNT;
            running_reg      <= 1'b0;
            timerEndFlag_reg <= `RST_END_FLAG;
            window_reg       <= 1'b0;
        end
        else if (ctrlLoad)
        begin
            // A reload clears the end flag; counting waits for the enable flag
            downCount_reg    <= {memWriteData[`CTRL_COUNT8_BIT],
                                 timerCountLow_reg};
            timerEndFlag_reg <= 1'b0;
            running_reg      <= enSet;
            window_reg       <= enSet;
        end
        else if (ctrlStop)
        begin
            running_reg <= 1'b0;
            window_reg  <= 1'b0;
        end
        else if (tick && !wrCtrl)
        begin
            if (countZero)
            begin
                // Stopping one tick after zero gives the value-plus-one window
                running_reg      <= 1'b0;
                window_reg       <= 1'b0;
                timerEndFlag_reg <= 1'b1;
            end
            else
                downCount_reg <= downCount_reg - `COUNT_ONE;
        end
    end

    // ------------------------------------------------------------------------
    // Tick prescaler
    // ------------------------------------------------------------------------
    // Restarting on every control write makes the first tick a full period late
    always @(posedge core_clk)
    begin
        if (reset)
            tickDiv_reg <= `TICK_ZERO;
        else if (wrCtrl || !running_reg)
            tickDiv_reg <= `TICK_ZERO;
        else
            tickDiv_reg <= tickDiv_reg + `TICK_STEP;
    end

    // ------------------------------------------------------------------------
    // Carrier generator
    // ------------------------------------------------------------------------
    always @*
    begin
        carrierHigh_next  = carrierHigh_reg;
        carrierCount_next = carrierCount_reg + `COUNT_ONE;
        case (carrierHigh_reg)
            CARRIER_LOW:
            begin
                if (!window_reg)
                    carrierCount_next = `RST_COUNT;
                else if (carrierCount_reg == lowPeriod_reg)
                begin
                    carrierCount_next = `RST_COUNT;
                    carrierHigh_next  = CARRIER_HIGH;
                end
            end
            CARRIER_HIGH:
            begin
                // A high phase runs to its end even after the timer end closes the window; a control write cuts it short
                if (carrierCount_reg == highPeriod_reg)
                begin
                    carrierCount_next = `RST_COUNT;
                    carrierHigh_next  = CARRIER_LOW;
                end
            end
            default:
            begin
                carrierCount_next = `RST_COUNT;
                carrierHigh_next  = CARRIER_LOW;
            end
        endcase
        if (wrCtrl)
        begin
            // Every start begins with a fresh low phase
            carrierCount_next = `RST_COUNT;
            carrierHigh_next  = CARRIER_LOW;
        end
    end

    // ------------------------------------------------------------------------
    // Carrier registers
    // ------------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            carrierCount_reg <= `RST_COUNT;
            carrierHigh_reg  <= CARRIER_LOW;
        end
        else
        begin
            carrierCount_reg <= carrierCount_next;
            carrierHigh_reg  <= carrierHigh_next;
        end
    end

    // ------------------------------------------------------------------------
    // Output pin and read data
    // ------------------------------------------------------------------------
    always @*
    begin
        if (carrierInhibit_reg)
            remote_next = timerOutputEnable_reg;
        else
            remote_next = carrierHigh_reg;
    end

    // The pin is registered so it never glitches while the phases switch
    always @(posedge core_clk)
    begin
        if (reset)
            remoteOutPin <= 1'b0;
        else
            remoteOutPin <= remote_next;
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @*
    begin
        case (memAddr)
            `ADDR_TIMER_COUNT_LOW: readData_next = timerCountLow_reg;
            `ADDR_TIMER_CONTROL:   readData_next = {timerEndFlag_reg, 5'h00,
                                       timerOutputEnable_reg, countBitEight_reg};
            `ADDR_LOW_PERIOD_LO:   readData_next = lowPeriod_reg[7:0];
            `ADDR_LOW_PERIOD_HI:   readData_next = hiByte(lowPeriod_reg[8], 1'b0);
            `ADDR_HIGH_PERIOD_LO:  readData_next = highPeriod_reg[7:0];
            `ADDR_HIGH_PERIOD_HI:  readData_next = hiByte(highPeriod_reg[8],
                                       carrierInhibit_reg);
            default:               readData_next = `RST_BYTE;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (reset)
            memReadData <= `RST_BYTE;
        else
            memReadData <= memRead ? readData_next : `RST_BYTE;
    end

endmodule // ir_remote_timer_carrier

/* verif/ir_led_model.sv */
module ir_led_model (
    // Drive side
    input  logic core_clk,
    input  logic remoteOutPin,
    input  logic clearCount,
    // Light seen
    output int   edgeCount,
    output int   highCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lastLevel = 1'b0;
    // An LED only senses the drive level; it never loads the pin
    always @(posedge core_clk)
    begin
        lastLevel <= remoteOutPin;
        if (clearCount)
        begin
            edgeCount <= 0;
            highCount <= 0;
        end
        else
        begin
            edgeCount <= edgeCount + ((remoteOutPin && !lastLevel) ? 1 : 0);
            highCount <= highCount + (remoteOutPin ? 1 : 0);
        end
    end
endmodule // ir_led_model

/* verif/ir_remote_timer_carrier_checker.sv */
module ir_remote_timer_carrier_checker (
    // Clock and reset
    input logic       core_clk,
    input logic       reset,
    // Register bus and pin
    input logic [7:0] memAddr,
    input logic       memWrite,
    input logic       memRead,
    input logic [7:0] memWriteData,
    input logic [7:0] memReadData,
    input logic       remoteOutPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Shadow flags, rebuilt from bus writes
    // ----------------------------------------
    logic inhReg;
    logic enReg;
    logic ctrlWr;
    assign ctrlWr = memWrite && memAddr == 8'h19;
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            inhReg <= 1'b1;
            enReg  <= 1'b0;
        end
        else
        begin
            if (memWrite && memAddr == 8'h1d)
                inhReg <= memWriteData[1];
            if (ctrlWr)
                enReg <= memWriteData[1];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Must hold through reset itself, so no disable here
    a_reset_pin_low: assert property (disable iff (1'b0) reset |=> !remoteOutPin)
        else $error("pin not low after reset");
    a_read_gated: assert property ((!memRead || memAddr < 8'h18 || memAddr > 8'h1d)
        |=> memReadData == 8'h00) else $error("read data not zero");
    a_ctrl_unused: assert property (memRead && memAddr == 8'h19
        |=> memReadData[6:2] == 5'h00) else $error("control unused bits set");
    a_upper_unused: assert property (memRead && (memAddr == 8'h1b || memAddr == 8'h1d)
        |=> memReadData[7:2] == 6'h00) else $error("period upper unused bits set");
    a_low_fix_zero: assert property (memRead && memAddr == 8'h1b
        |=> !memReadData[1]) else $error("low period bit nine set");
    // Pin lags internal state by one register stage
    a_follow_enable: assert property ($past(inhReg) |-> remoteOutPin == $past(enReg))
        else $error("inhibited pin not following enable");
    a_burst_low: assert property (ctrlWr && memWriteData[1] && !enReg && !inhReg
        |=> !remoteOutPin [*3]) else $error("burst did not start low");
    a_end_cleared: assert property (ctrlWr ##[1:4] (memRead && memAddr == 8'h19)
        |=> !memReadData[7]) else $error("end flag not cleared by load");
    c_timer_start: cover property (ctrlWr && memWriteData[1]);
    c_carrier_rise: cover property (!inhReg && $rose(remoteOutPin));
    c_unmapped: cover property (memRead && memAddr == 8'h10);
endmodule // ir_remote_timer_carrier_checker

bind ir_remote_timer_carrier ir_remote_timer_carrier_checker i_ir_remote_timer_carrier_checker (
    .core_clk(core_clk), .reset(reset), .memAddr(memAddr), .memWrite(memWrite),
    .memRead(memRead), .memWriteData(memWriteData), .memReadData(memReadData),
    .remoteOutPin(remoteOutPin));

/* verif/test_ir_remote_timer_carrier.sv */
module test_ir_remote_timer_carrier;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] memAddr = 8'h00;
    logic       memWrite = 1'b0;
    logic       memRead = 1'b0;
    logic [7:0] memWriteData = 8'h00;
    wire  [7:0] memReadData;
    wire        remoteOutPin;
    logic       clearCount = 1'b1;
    int         edgeCount;
    int         highCount;
    int         n_errors = 0;
    int         n_checks = 0;
    int         cyc;
    logic [7:0] rdata;
    logic [7:0] adr [7] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h10};
    logic [7:0] rstv [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    logic [7:0] mskv [7] = '{8'hff, 8'h80, 8'hff, 8'h01, 8'hff, 8'h03, 8'h00};
    ir_remote_timer_carrier i_ir_remote_timer_carrier (.core_clk(core_clk), .reset(reset),
        .memAddr(memAddr), .memWrite(memWrite), .memRead(memRead),
        .memWriteData(memWriteData), .memReadData(memReadData), .remoteOutPin(remoteOutPin));
    ir_led_model i_ir_led_model (.core_clk(core_clk), .remoteOutPin(remoteOutPin),
        .clearCount(clearCount), .edgeCount(edgeCount), .highCount(highCount));
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        memAddr <= a;
        memWriteData <= d;
        memWrite <= 1'b1;
        @(posedge core_clk);
        memWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        memAddr <= a;
        memRead <= 1'b1;
        @(posedge core_clk);
        memRead <= 1'b0;
        #1 rdata = memReadData;
        @(posedge core_clk);
    endtask
    // Low byte rewritten mid-run: must not disturb the running count
    task automatic run(input logic [8:0] n);
        int e;
        e = (n + 1) * 64;
        wr(8'h18, n[7:0]);
        wr(8'h19, {7'h01, n[8]});
        wr(8'h18, ~n[7:0]);
        cyc = 3;
        rdata = 8'h00;
        while (rdata[7] !== 1'b1 && cyc < 40000)
        begin
            rd(8'h19);
            cyc += 2;
        end
        if (cyc >= 40000)
        begin
            n_errors++;
            print_verdict();
        end
        chk("window length", 1'b1, (cyc > e - 6) && (cyc < e + 6));
        chk("end flag", {7'h41, n[8]}, rdata);
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            rd(adr[i]);
            chk("reset value", rstv[i], rdata);
        end
        for (int i = 0; i < 7; i++)
            if (i != 1)
                wr(adr[i], 8'hff);
        for (int i = 0; i < 7; i++)
        begin
            rd(adr[i]);
            chk("masked readback", mskv[i], rdata);
        end
        run(9'h000);
        run(9'h103);
        chk("inhibited pin", 1'b1, remoteOutPin);
        wr(8'h18, 8'h01);
        wr(8'h19, 8'h02);
        repeat (100) @(posedge core_clk);
        wr(8'h19, 8'h00);
        rd(8'h19);
        chk("stopped control", 8'h00, rdata);
        chk("stopped pin", 1'b0, remoteOutPin);
        run(9'h001);
        wr(8'h19, 8'h00);
        wr(8'h1a, 8'h03);
        wr(8'h1b, 8'h00);
        wr(8'h1c, 8'h0c);
        wr(8'h1d, 8'h00);
        clearCount <= 1'b0;
        run(9'h001);
        // The last high phase may still be finishing when the end flag is seen
        repeat (20) @(posedge core_clk);
        chk("carrier pulses", 8, edgeCount);
        chk("carrier high clocks", 104, highCount);
        chk("pin after burst", 1'b0, remoteOutPin);
        print_verdict();
    end
endmodule // test_ir_remote_timer_carrier
